// >>> hdl/tec_pkg.sv
// Shared constants for the terminal emulation compatibility register set
package tec_pkg;

  // ==========================================================================
  // Host I/O map
  localparam logic [9:0] TEC_CURSOR_LOW_ADDR = 10'h2d2;
  localparam logic [9:0] TEC_CURSOR_HIGH_ADDR = 10'h2d3;
  localparam logic [9:0] TEC_LINK_CONTROL_ADDR = 10'h2d4;
  localparam logic [9:0] TEC_KEYSTROKE_ADDR = 10'h2d5;
  localparam logic [9:0] TEC_STATION_ID_ADDR = 10'h2d6;
  localparam logic [9:0] TEC_SEGMENT_ADDR = 10'h2d7;
  localparam logic [9:0] TEC_PAGES_LOW_ADDR = 10'h2d8;
  localparam logic [9:0] TEC_PAGES_HIGH_ADDR = 10'h2d9;
  localparam logic [9:0] TEC_PRINTER_FLAGS_ADDR = 10'h2da;

  // ==========================================================================
  // Link control field positions
  localparam int TEC_CTL_ENABLE = 0;
  localparam int TEC_CTL_DISTRIBUTED = 1;
  localparam int TEC_CTL_PRINTER = 2;
  localparam int TEC_CTL_KEY_OFFERED = 3;
  localparam int TEC_CTL_STATUS_REQ = 4;
  localparam int TEC_CTL_TEST = 5;
  localparam int TEC_CTL_COND_INT = 6;
  localparam int TEC_CTL_INT_DISABLE = 7;

  // ==========================================================================
  // Printer poll flag positions
  localparam int TEC_PRN_ALARM = 5;
  localparam int TEC_PRN_DISABLE = 6;
  localparam int TEC_PRN_ENABLE = 7;

  // ==========================================================================
  // Values after reset and fixed values
  localparam logic [7:0] TEC_CONTROL_RESET = 8'h80;
  localparam logic [7:0] TEC_BYTE_RESET = 8'h00;
  localparam logic [15:0] TEC_CURSOR_RESET = 16'h0000;
  localparam logic [15:0] TEC_CURSOR_HOME = 16'h0000;
  localparam logic [7:0] TEC_SEGMENT_VALUE = 8'hce;
  localparam logic [2:0] TEC_CURSOR_HIGH_ZERO = 3'h0;
  localparam logic [7:0] TEC_READ_NONE = 8'h00;

  // ==========================================================================
  // Operating modes
  typedef enum logic [1:0] {
    TEC_MODE_DISPLAY,
    TEC_MODE_PRINTER,
    TEC_MODE_DISTRIBUTED
  } tec_mode_t;

endpackage

// >>> hdl/tec_flag_byte.sv
// Eight sticky flags set by hardware and cleared by writing ones
`timescale 1ns/100ps
`default_nettype none
module tec_flag_byte
  import tec_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] set_bits,
  input wire logic clr_write,
  input wire logic [7:0] clr_bits,
  output logic [7:0] flags
);

  // ==========================================================================
  // Flag storage
  logic [7:0] flags_q;
  logic [7:0] flags_d;

  // A set in the same cycle as its clear wins, so no event is lost
  always_comb begin
    flags_d = flags_q;
    if (clr_write) begin
      flags_d = flags_d & ~clr_bits;
    end
    flags_d = flags_d | set_bits;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_q <= TEC_BYTE_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

endmodule
`default_nettype wire

// >>> hdl/tec_registers.sv
// Host visible compatibility registers of the terminal emulation adapter
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Show cursor low byte; in display mode its change sets cursor-changed status.
// - Cursor high byte reads with its top three bits forced to zero.
// - Host writes to both cursor bytes are dropped.
// - Host sets enable bit; either side clears; first poll answer is power-on reset.
// - Control bit 1 chooses distributed-function mode, else control-unit-terminal.
// - Bit 2 picks display or printer, only in control-unit-terminal mode.
// - Host offers a keystroke with bit 3; poll acknowledge or reset clears it.
// - Host requests status acknowledge with bit 4; poll acknowledge clears it.
// - Test bit 5 is stored and does nothing.
// - Display mode: bit 6 hides cursor interrupt while cursor is inhibited.
// - Printer mode: bit 6 loads zero into the cursor address.
// - Bit 7 is set at reset and blocks every interrupt.
// - The keystroke code goes out to the link inverted.
// - The station identifier goes out to the link inverted.
// - Segment register always reads the fixed value; writes are ignored.
// - One flag per modified 256-byte page, pages 0-7 low, 8-15 high.
// - Printer mode only: alarm, disable, enable polls set flags 5, 6, 7.
// - Interrupt pending when any status bit 0-5 is set and unmasked.
module tec_registers
  import tec_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [9:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  output logic IO_RVALID,
  input wire logic CU_CURSOR_LOAD,
  input wire logic [15:0] CU_CURSOR_ADDR,
  input wire logic CU_POLL,
  input wire logic CU_POLL_ACK,
  input wire logic CU_RESET,
  input wire logic CU_DISCONNECT,
  input wire logic CU_PAGE_WRITE,
  input wire logic [3:0] CU_PAGE_INDEX,
  input wire logic CU_ALARM_POLL,
  input wire logic CU_DISABLE_POLL,
  input wire logic CU_ENABLE_POLL,
  input wire logic CU_INHIBIT_CURSOR,
  input wire logic [4:0] OTHER_STATUS,
  input wire logic CURSOR_FLAG_CLR,
  output logic [15:0] CURSOR_ADDR,
  output logic [7:0] LINK_CONTROL,
  output logic [1:0] MODE,
  output logic POR_RESPONSE_DUE,
  output logic [7:0] KEYSTROKE_TO_LINK,
  output logic [7:0] STATION_ID_TO_LINK,
  output logic CURSOR_CHANGED,
  output logic INT_PENDING
);

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] page_onehot(input logic [3:0] idx);
    logic [15:0] v;
    v = 16'h0000;
    v[idx] = 1'b1;
    return v;
  endfunction

  function automatic tec_mode_t mode_of(input logic [7:0] ctl);
    tec_mode_t m;
    m = TEC_MODE_DISPLAY;
    if (ctl[TEC_CTL_DISTRIBUTED]) begin
      m = TEC_MODE_DISTRIBUTED;
    end else if (ctl[TEC_CTL_PRINTER]) begin
      m = TEC_MODE_PRINTER;
    end
    return m;
  endfunction

  // ==========================================================================
  // Decode
  logic wr_control;
  logic wr_keystroke;
  logic wr_station;
  logic wr_pages_low;
  logic wr_pages_high;
  logic wr_printer;
  tec_mode_t mode;

  assign wr_control = IO_WR && (IO_ADDR == TEC_LINK_CONTROL_ADDR);
  assign wr_keystroke = IO_WR && (IO_ADDR == TEC_KEYSTROKE_ADDR);
  assign wr_station = IO_WR && (IO_ADDR == TEC_STATION_ID_ADDR);
  assign wr_pages_low = IO_WR && (IO_ADDR == TEC_PAGES_LOW_ADDR);
  assign wr_pages_high = IO_WR && (IO_ADDR == TEC_PAGES_HIGH_ADDR);
  assign wr_printer = IO_WR && (IO_ADDR == TEC_PRINTER_FLAGS_ADDR);

  // ==========================================================================
  // State
  logic [7:0] ctl_q;
  logic [7:0] ctl_d;
  logic [15:0] cursor_q;
  logic [15:0] cursor_d;
  logic por_q;
  logic por_d;
  logic [7:0] key_inv_q;
  logic [7:0] key_inv_d;
  logic [7:0] id_inv_q;
  logic [7:0] id_inv_d;
  logic cur_chg_q;
  logic cur_chg_d;
  logic int_q;
  logic int_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  tec_mode_t mode_q;
  tec_mode_t mode_d;
  logic [7:0] pages_low;
  logic [7:0] pages_high;
  logic [7:0] printer_flags;
  logic [15:0] page_set;
  logic [7:0] printer_set;
  logic [15:0] cursor_new;
  logic cursor_event;
  logic cursor_irq_ok;

  // Registered beside the control byte, so the mode port comes from a flip-flop
  assign mode = mode_q;

  // Both bytes come from one load, so no torn address is ever visible
  // joint cursor load
  assign cursor_new = {TEC_CURSOR_HIGH_ZERO, CU_CURSOR_ADDR[12:0]};

  assign page_set = CU_PAGE_WRITE ? page_onehot(CU_PAGE_INDEX) : 16'h0000;

  always_comb begin
    printer_set = TEC_BYTE_RESET;
    if (mode == TEC_MODE_PRINTER) begin
      printer_set[TEC_PRN_ALARM] = CU_ALARM_POLL;
      printer_set[TEC_PRN_DISABLE] = CU_DISABLE_POLL;
      printer_set[TEC_PRN_ENABLE] = CU_ENABLE_POLL;
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    ctl_d = ctl_q;
    cursor_d = cursor_q;
    por_d = por_q;
    key_inv_d = key_inv_q;
    id_inv_d = id_inv_q;
    cur_chg_d = cur_chg_q;
    cursor_event = 1'b0;
    if (CU_POLL_ACK) begin
      ctl_d[TEC_CTL_STATUS_REQ] = 1'b0;
    end
    if (CU_POLL_ACK || CU_RESET) begin
      ctl_d[TEC_CTL_KEY_OFFERED] = 1'b0;
    end
    if (CU_DISCONNECT) begin
      ctl_d[TEC_CTL_ENABLE] = 1'b0;
    end
    if (CU_POLL) begin
      por_d = 1'b0;
    end
    // Host write lands after link clears so a fresh host set is not lost
    // stored control
    if (wr_control) begin
      ctl_d = IO_WDATA;
      if (IO_WDATA[TEC_CTL_ENABLE] && !ctl_q[TEC_CTL_ENABLE]) begin
        por_d = 1'b1;
      end
    end
    if (wr_keystroke) begin
      key_inv_d = ~IO_WDATA;
    end
    if (wr_station) begin
      id_inv_d = ~IO_WDATA;
    end
    if (CU_CURSOR_LOAD) begin
      cursor_d = cursor_new;
      cursor_event = (cursor_new != cursor_q);
    end
    if ((mode == TEC_MODE_PRINTER) && ctl_q[TEC_CTL_COND_INT]) begin
      cursor_d = TEC_CURSOR_HOME;
    end
    if (CURSOR_FLAG_CLR) begin
      cur_chg_d = 1'b0;
    end
    if (cursor_event && (mode == TEC_MODE_DISPLAY)) begin
      cur_chg_d = 1'b1;
    end
    mode_d = mode_of(ctl_d);
  end

  // ==========================================================================
  // Interrupt pending
  always_comb begin
    cursor_irq_ok = !(CU_INHIBIT_CURSOR && ctl_q[TEC_CTL_COND_INT] && (mode == TEC_MODE_DISPLAY));
    int_d = ((cur_chg_q && cursor_irq_ok) || (|OTHER_STATUS)) && !ctl_q[TEC_CTL_INT_DISABLE];
  end

  // ==========================================================================
  // Read path
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = IO_RD;
    if (IO_RD) begin
      unique case (IO_ADDR)
        TEC_CURSOR_LOW_ADDR: rdata_d = cursor_q[7:0];
        TEC_CURSOR_HIGH_ADDR: rdata_d = cursor_q[15:8];
        TEC_LINK_CONTROL_ADDR: rdata_d = ctl_q;
        TEC_SEGMENT_ADDR: rdata_d = TEC_SEGMENT_VALUE;
        TEC_PAGES_LOW_ADDR: rdata_d = pages_low;
        TEC_PAGES_HIGH_ADDR: rdata_d = pages_high;
        TEC_PRINTER_FLAGS_ADDR: rdata_d = printer_flags;
        default: rdata_d = TEC_READ_NONE;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctl_q <= TEC_CONTROL_RESET;
      cursor_q <= TEC_CURSOR_RESET;
      por_q <= 1'b0;
      key_inv_q <= TEC_BYTE_RESET;
      id_inv_q <= TEC_BYTE_RESET;
      cur_chg_q <= 1'b0;
      int_q <= 1'b0;
      rdata_q <= TEC_READ_NONE;
      rvalid_q <= 1'b0;
      mode_q <= TEC_MODE_DISPLAY;
    end else begin
      ctl_q <= ctl_d;
      cursor_q <= cursor_d;
      por_q <= por_d;
      key_inv_q <= key_inv_d;
      id_inv_q <= id_inv_d;
      cur_chg_q <= cur_chg_d;
      int_q <= int_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      mode_q <= mode_d;
    end
  end

  // ==========================================================================
  // Page and printer flags
  // low pages 0-7
  tec_flag_byte u_pages_low (
    .clk(CLK),
    .rst(SYS_RST),
    .set_bits(page_set[7:0]),
    .clr_write(wr_pages_low),
    .clr_bits(IO_WDATA),
    .flags(pages_low)
  );

  tec_flag_byte u_pages_high (
    .clk(CLK),
    .rst(SYS_RST),
    .set_bits(page_set[15:8]),
    .clr_write(wr_pages_high),
    .clr_bits(IO_WDATA),
    .flags(pages_high)
  );

  // Undefined low bits never get a set source, so they read zero
  tec_flag_byte u_printer (
    .clk(CLK),
    .rst(SYS_RST),
    .set_bits(printer_set),
    .clr_write(wr_printer),
    .clr_bits(IO_WDATA),
    .flags(printer_flags)
  );

  // ==========================================================================
  // Outputs
  assign IO_RDATA = rdata_q;
  assign IO_RVALID = rvalid_q;
  assign CURSOR_ADDR = cursor_q;
  assign LINK_CONTROL = ctl_q;
  assign POR_RESPONSE_DUE = por_q;
  assign KEYSTROKE_TO_LINK = key_inv_q;
  assign STATION_ID_TO_LINK = id_inv_q;
  assign CURSOR_CHANGED = cur_chg_q;
  assign INT_PENDING = int_q;
  assign MODE = mode_q;

endmodule
`default_nettype wire

// >>> sim/tec_registers_sva.sv
// Port assertions for the compatibility register set
`timescale 1ns/100ps
`default_nettype none
module tec_registers_sva
  import tec_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [9:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_WDATA,
  input wire logic [7:0] IO_RDATA,
  input wire logic IO_RVALID,
  input wire logic CU_CURSOR_LOAD,
  input wire logic [15:0] CU_CURSOR_ADDR,
  input wire logic CU_POLL_ACK,
  input wire logic [4:0] OTHER_STATUS,
  input wire logic CURSOR_FLAG_CLR,
  input wire logic [15:0] CURSOR_ADDR,
  input wire logic [7:0] LINK_CONTROL,
  input wire logic [1:0] MODE,
  input wire logic POR_RESPONSE_DUE,
  input wire logic [7:0] KEYSTROKE_TO_LINK,
  input wire logic [7:0] STATION_ID_TO_LINK,
  input wire logic CURSOR_CHANGED,
  input wire logic INT_PENDING
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic ctl_wr;
  logic hold_zero;
  // Host writes to control win over link clears in the same cycle
  assign ctl_wr = IO_WR && IO_ADDR == TEC_LINK_CONTROL_ADDR;
  assign hold_zero = MODE == TEC_MODE_PRINTER && LINK_CONTROL[6];
  // ====================================
  // Sequences
  sequence s_load;
    CU_CURSOR_LOAD && !hold_zero;
  endsequence
  sequence s_unmasked;
    !LINK_CONTROL[7] && OTHER_STATUS != 5'h00;
  endsequence
  // ====================================
  // Properties
  a_seg_fixed: assert property (IO_RD && IO_ADDR == TEC_SEGMENT_ADDR |=> IO_RVALID && IO_RDATA == 8'hce)
    else $error("Segment read value wrong");
  a_cursor_load: assert property (s_load |=> CURSOR_ADDR == {3'h0, $past(CU_CURSOR_ADDR[12:0])})
    else $error("Cursor load wrong");
  a_cursor_home: assert property (hold_zero |=> CURSOR_ADDR == 16'h0000)
    else $error("Cursor not held at zero");
  a_cursor_ro: assert property (IO_WR && IO_ADDR[9:1] == 9'h169 && !CU_CURSOR_LOAD && !LINK_CONTROL[6]
    |=> $stable(CURSOR_ADDR))
    else $error("Host changed cursor");
  a_cursor_flag: assert property (MODE == TEC_MODE_DISPLAY && CU_CURSOR_LOAD && !CURSOR_FLAG_CLR
    && CU_CURSOR_ADDR[12:0] != CURSOR_ADDR[12:0] |=> CURSOR_CHANGED)
    else $error("Cursor change not flagged");
  a_por_due: assert property (ctl_wr && IO_WDATA[0] && !LINK_CONTROL[0] |=> POR_RESPONSE_DUE)
    else $error("Power-on answer not due");
  a_ack_clears: assert property (CU_POLL_ACK && !ctl_wr |=> LINK_CONTROL[4:3] == 2'h0)
    else $error("Acknowledge left offer bits");
  a_key_invert: assert property (IO_WR && IO_ADDR == TEC_KEYSTROKE_ADDR
    |=> KEYSTROKE_TO_LINK == ~$past(IO_WDATA))
    else $error("Keystroke not inverted");
  a_id_invert: assert property (IO_WR && IO_ADDR == TEC_STATION_ID_ADDR
    |=> STATION_ID_TO_LINK == ~$past(IO_WDATA))
    else $error("Identifier not inverted");
  a_mask_blocks: assert property (LINK_CONTROL[7] [*2] |-> !INT_PENDING)
    else $error("Masked interrupt raised");
  a_pend_raise: assert property (s_unmasked ##1 !LINK_CONTROL[7] |-> INT_PENDING)
    else $error("Pending flag missing");
endmodule
bind tec_registers tec_registers_sva chk (.CLK(CLK), .SYS_RST(SYS_RST), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR),
  .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .IO_RVALID(IO_RVALID), .CU_CURSOR_LOAD(CU_CURSOR_LOAD),
  .CU_CURSOR_ADDR(CU_CURSOR_ADDR), .CU_POLL_ACK(CU_POLL_ACK), .OTHER_STATUS(OTHER_STATUS),
  .CURSOR_FLAG_CLR(CURSOR_FLAG_CLR), .CURSOR_ADDR(CURSOR_ADDR), .LINK_CONTROL(LINK_CONTROL), .MODE(MODE),
  .POR_RESPONSE_DUE(POR_RESPONSE_DUE), .KEYSTROKE_TO_LINK(KEYSTROKE_TO_LINK),
  .STATION_ID_TO_LINK(STATION_ID_TO_LINK), .CURSOR_CHANGED(CURSOR_CHANGED), .INT_PENDING(INT_PENDING));
`default_nettype wire

// >>> sim/tec_cu_model.sv
// Behavioural control unit that sends link events
`timescale 1ns/100ps
`default_nettype none
module tec_cu_model
(
  input wire logic clk,
  output logic load,
  output logic poll,
  output logic ack,
  output logic rst_cmd,
  output logic disc,
  output logic page,
  output logic alarm,
  output logic dis,
  output logic ena,
  output var logic inh,
  output var logic [15:0] addr,
  output logic [3:0] idx
);
  logic [8:0] ev;
  assign {ena, dis, alarm, page, disc, rst_cmd, ack, poll, load} = ev;
  assign idx = addr[3:0];
  initial begin
    ev = 9'h000;
    inh = 1'b0;
    addr = 16'h0000;
  end
  task automatic fire(input logic [9:0] m, input logic [15:0] a);
    @(posedge clk);
    ev <= m[8:0];
    inh <= m[9];
    addr <= a;
    @(posedge clk);
    ev <= 9'h000;
    // Released bus shows a flipped value, never the old one
    addr <= ~a;
    #1;
  endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the compatibility registers
`timescale 1ns/100ps
`default_nettype none
module testbench
  import tec_pkg::*;
;
  logic CLK = 1'b0, SYS_RST = 1'b1, IO_WR = 1'b0, IO_RD = 1'b0, CURSOR_FLAG_CLR = 1'b0;
  logic [9:0] IO_ADDR = 10'h000;
  logic [7:0] IO_WDATA = 8'h00;
  logic [4:0] OTHER_STATUS = 5'h00;
  logic [7:0] IO_RDATA, LINK_CONTROL, KEYSTROKE_TO_LINK, STATION_ID_TO_LINK;
  logic [15:0] CURSOR_ADDR, CU_CURSOR_ADDR;
  logic [1:0] MODE;
  logic [3:0] CU_PAGE_INDEX;
  logic IO_RVALID, POR_RESPONSE_DUE, CURSOR_CHANGED, INT_PENDING, CU_CURSOR_LOAD, CU_POLL, CU_POLL_ACK;
  logic CU_RESET, CU_DISCONNECT, CU_PAGE_WRITE, CU_ALARM_POLL, CU_DISABLE_POLL, CU_ENABLE_POLL, CU_INHIBIT_CURSOR;
  int error_cnt = 0, checks_done = 0, cycles = 0;
  tec_registers uut (.CLK(CLK), .SYS_RST(SYS_RST), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD),
    .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .IO_RVALID(IO_RVALID), .CU_CURSOR_LOAD(CU_CURSOR_LOAD),
    .CU_CURSOR_ADDR(CU_CURSOR_ADDR), .CU_POLL(CU_POLL), .CU_POLL_ACK(CU_POLL_ACK), .CU_RESET(CU_RESET),
    .CU_DISCONNECT(CU_DISCONNECT), .CU_PAGE_WRITE(CU_PAGE_WRITE), .CU_PAGE_INDEX(CU_PAGE_INDEX),
    .CU_ALARM_POLL(CU_ALARM_POLL), .CU_DISABLE_POLL(CU_DISABLE_POLL), .CU_ENABLE_POLL(CU_ENABLE_POLL),
    .CU_INHIBIT_CURSOR(CU_INHIBIT_CURSOR), .OTHER_STATUS(OTHER_STATUS), .CURSOR_FLAG_CLR(CURSOR_FLAG_CLR),
    .CURSOR_ADDR(CURSOR_ADDR), .LINK_CONTROL(LINK_CONTROL), .MODE(MODE), .POR_RESPONSE_DUE(POR_RESPONSE_DUE),
    .KEYSTROKE_TO_LINK(KEYSTROKE_TO_LINK), .STATION_ID_TO_LINK(STATION_ID_TO_LINK),
    .CURSOR_CHANGED(CURSOR_CHANGED), .INT_PENDING(INT_PENDING));
  tec_cu_model cu (.clk(CLK), .load(CU_CURSOR_LOAD), .poll(CU_POLL), .ack(CU_POLL_ACK), .rst_cmd(CU_RESET),
    .disc(CU_DISCONNECT), .page(CU_PAGE_WRITE), .alarm(CU_ALARM_POLL), .dis(CU_DISABLE_POLL),
    .ena(CU_ENABLE_POLL), .inh(CU_INHIBIT_CURSOR), .addr(CU_CURSOR_ADDR), .idx(CU_PAGE_INDEX));
  always #10 CLK = ~CLK;
  // ====================================
  // Shared tasks
  task automatic stop_test();
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge CLK);
    IO_ADDR <= a;
    IO_WDATA <= d;
    IO_WR <= 1'b1;
    @(posedge CLK);
    IO_WR <= 1'b0;
    #1;
  endtask
  // Mask hides bits whose value is left open
  task automatic rd(input logic [9:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge CLK);
    IO_ADDR <= a;
    IO_RD <= 1'b1;
    @(posedge CLK);
    IO_RD <= 1'b0;
    #1;
    chk(16'(IO_RVALID), 16'h0001);
    chk(16'(IO_RDATA & m), 16'(exp));
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic clear_flag();
    @(posedge CLK);
    CURSOR_FLAG_CLR <= 1'b1;
    @(posedge CLK);
    CURSOR_FLAG_CLR <= 1'b0;
    tick(1);
  endtask
  // ====================================
  // Scenarios
  task automatic t_regs();
    rd(TEC_LINK_CONTROL_ADDR, 8'hff, 8'h80);
    wr(TEC_SEGMENT_ADDR, 8'h00);
    rd(TEC_SEGMENT_ADDR, 8'hff, 8'hce);
    rd(TEC_KEYSTROKE_ADDR, 8'hff, 8'h00);
    rd(10'h2df, 8'hff, 8'h00);
  endtask
  task automatic t_link();
    wr(TEC_STATION_ID_ADDR, 8'h31);
    chk(16'(STATION_ID_TO_LINK), 16'h00ce);
    wr(TEC_LINK_CONTROL_ADDR, 8'h81);
    chk(16'(POR_RESPONSE_DUE), 16'h0001);
    cu.fire(10'h002, 16'h0000);
    chk(16'(POR_RESPONSE_DUE), 16'h0000);
    cu.fire(10'h010, 16'h0000);
    rd(TEC_LINK_CONTROL_ADDR, 8'hff, 8'h80);
  endtask
  task automatic t_keys();
    wr(TEC_KEYSTROKE_ADDR, 8'h5a);
    chk(16'(KEYSTROKE_TO_LINK), 16'h00a5);
    wr(TEC_LINK_CONTROL_ADDR, 8'h99);
    cu.fire(10'h004, 16'h0000);
    rd(TEC_LINK_CONTROL_ADDR, 8'hff, 8'h81);
    wr(TEC_LINK_CONTROL_ADDR, 8'h89);
    cu.fire(10'h008, 16'h0000);
    rd(TEC_LINK_CONTROL_ADDR, 8'hff, 8'h81);
    wr(TEC_LINK_CONTROL_ADDR, 8'ha1);
    rd(TEC_LINK_CONTROL_ADDR, 8'hff, 8'ha1);
  endtask
  task automatic t_cursor();
    wr(TEC_LINK_CONTROL_ADDR, 8'h00);
    cu.fire(10'h001, 16'hffff);
    chk(CURSOR_ADDR, 16'h1fff);
    chk(16'(CURSOR_CHANGED), 16'h0001);
    rd(TEC_CURSOR_HIGH_ADDR, 8'hff, 8'h1f);
    rd(TEC_CURSOR_LOW_ADDR, 8'hff, 8'hff);
    chk(16'(INT_PENDING), 16'h0001);
    wr(TEC_CURSOR_LOW_ADDR, 8'h00);
    wr(TEC_CURSOR_HIGH_ADDR, 8'h00);
    chk(CURSOR_ADDR, 16'h1fff);
    clear_flag();
    wr(TEC_LINK_CONTROL_ADDR, 8'h40);
    cu.fire(10'h201, 16'h0123);
    tick(2);
    chk(16'(CURSOR_CHANGED), 16'h0001);
    chk(16'(INT_PENDING), 16'h0000);
    clear_flag();
    wr(TEC_LINK_CONTROL_ADDR, 8'h80);
    @(posedge CLK);
    OTHER_STATUS <= 5'h01;
    tick(3);
    chk(16'(INT_PENDING), 16'h0000);
    wr(TEC_LINK_CONTROL_ADDR, 8'h00);
    tick(2);
    chk(16'(INT_PENDING), 16'h0001);
    @(posedge CLK);
    OTHER_STATUS <= 5'h00;
  endtask
  task automatic t_printer();
    wr(TEC_LINK_CONTROL_ADDR, 8'h04);
    chk(16'(MODE), 16'(TEC_MODE_PRINTER));
    wr(TEC_STATION_ID_ADDR, 8'hfe);
    chk(16'(STATION_ID_TO_LINK), 16'h0001);
    cu.fire(10'h1c0, 16'h0000);
    rd(TEC_PRINTER_FLAGS_ADDR, 8'he0, 8'he0);
    wr(TEC_PRINTER_FLAGS_ADDR, 8'he0);
    rd(TEC_PRINTER_FLAGS_ADDR, 8'he0, 8'h00);
    wr(TEC_LINK_CONTROL_ADDR, 8'h44);
    tick(1);
    chk(CURSOR_ADDR, 16'h0000);
    wr(TEC_LINK_CONTROL_ADDR, 8'h06);
    chk(16'(MODE), 16'(TEC_MODE_DISTRIBUTED));
    cu.fire(10'h040, 16'h0000);
    rd(TEC_PRINTER_FLAGS_ADDR, 8'he0, 8'h00);
    wr(TEC_LINK_CONTROL_ADDR, 8'h00);
    chk(16'(MODE), 16'(TEC_MODE_DISPLAY));
  endtask
  // Each page alone, so a swapped bit or half cannot hide
  task automatic t_pages();
    for (int i = 0; i < 16; i++) begin
      cu.fire(10'h020, 16'(i));
      rd(i < 8 ? TEC_PAGES_LOW_ADDR : TEC_PAGES_HIGH_ADDR, 8'hff, 8'h01 << (i % 8));
      wr(i < 8 ? TEC_PAGES_LOW_ADDR : TEC_PAGES_HIGH_ADDR, 8'h01 << (i % 8));
    end
    rd(TEC_PAGES_HIGH_ADDR, 8'hff, 8'h00);
  endtask
  // ====================================
  // Main sequence and time limit
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge CLK);
    SYS_RST <= 1'b0;
    t_regs();
    t_link();
    t_keys();
    t_cursor();
    t_printer();
    t_pages();
    stop_test();
  end
endmodule
`default_nettype wire
